// ==== hw/smem_pkg.sv ====
package smem_pkg;
   localparam int SMEM_ADDR_W = 13;
   localparam int SMEM_DEPTH = 8192;
   localparam int SMEM_DATA_W = 8;
   localparam int SMEM_SEL_W = 3;
   localparam int SMEM_BYTE_BITS = 8;
   // type code of the address word; value arbitrary
   localparam logic [3:0] SMEM_TYPE_CODE = 4'h5;
   localparam logic [2:0] SMEM_BIT_LAST = 3'h7;
   localparam logic [2:0] SMEM_BIT_FIRST = 3'h0;
   localparam logic SMEM_DIR_READ = 1'b1;

   typedef enum logic [2:0] {
      SMEM_IDLE, SMEM_DEVADDR, SMEM_ADDRHI, SMEM_ADDRLO,
      SMEM_WDATA, SMEM_RDATA, SMEM_RACK
   } smem_state_e;

   typedef struct packed {
      logic sclIn;
      logic sdaIn;
   } smem_pins_s;

   typedef struct packed {
      logic we;
      logic [SMEM_ADDR_W-1:0] addr;
      logic [SMEM_DATA_W-1:0] wdata;
   } smem_memreq_s;
endpackage

// ==== hw/smem_array.sv ====
`timescale 1ns/10ps
module smem_array #(
   parameter int ADDR_W = smem_pkg::SMEM_ADDR_W,
   parameter int DATA_W = smem_pkg::SMEM_DATA_W
) (
   input wire logic ref_clk,
   input wire logic we,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   output logic [DATA_W-1:0] rdata
);
   import smem_pkg::*;
   // contents are not cleared by reset: the array is nonvolatile
   logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

   always_ff @(posedge ref_clk) begin
      if (we) begin
         cells[addr] <= wdata;
      end
      rdata <= cells[addr];
   end
endmodule

// ==== hw/smem_i2c_slave.sv ====
`timescale 1ns/10ps
// How it works
// - write protect pin high blocks every array write.
// - write protect pin low lets every location be written.
// - reads proceed whatever the write protect level.
// - an open write protect pin has no pull-down here; writeProtect is a plain input and must be driven.
// - byte write: address word, two address bytes, data byte, each acked; the data byte is nacked while write protect is high.
// - further data bytes go to consecutive addresses.
// - the write address wraps from last location to zero.
// - each byte is committed at its ack; no write wait after stop.
// - current address read returns byte after last accessed one.
// - after the final location the current read returns address zero.
// - address counter is zero after reset until an address phase loads it or a current read advances it.
// - current read: ack address word, send 8 bits, master nacks.
// - random read: load address, repeated start, read word.
// - sequential read continues while acked, wrapping to zero.
// - ack address word only on type code and select pins match.
// - sample data on rising clock, change output after falling clock.
// - stop before an ack abandons the operation to standby.
// - data line is released after a nack from the master.
module smem_i2c_slave (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic writeProtect,
   input wire logic [smem_pkg::SMEM_SEL_W-1:0] selectPins,
   output logic busy
);
   import smem_pkg::*;

   // ----------------------------------------------------------------
   // bus edge detection
   // ----------------------------------------------------------------
   smem_pins_s pins_r, pins_nxt;
   logic sclRise, sclFall, startSeen, stopSeen;

   always_comb begin
      pins_nxt.sclIn = scl;
      pins_nxt.sdaIn = sdaIn;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pins_r <= '{sclIn: 1'b1, sdaIn: 1'b1};
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign sclRise = scl & ~pins_r.sclIn;
   assign sclFall = ~scl & pins_r.sclIn;
   assign startSeen = scl & pins_r.sclIn & ~sdaIn & pins_r.sdaIn;
   assign stopSeen = scl & pins_r.sclIn & sdaIn & ~pins_r.sdaIn;

   // ----------------------------------------------------------------
   // array
   // ----------------------------------------------------------------
   smem_memreq_s memReq;
   logic [SMEM_DATA_W-1:0] memRdata;

   smem_array #(
      .ADDR_W(SMEM_ADDR_W),
      .DATA_W(SMEM_DATA_W)
   ) uArray (
      .ref_clk(ref_clk),
      .we(memReq.we),
      .addr(memReq.addr),
      .wdata(memReq.wdata),
      .rdata(memRdata)
   );

   // ----------------------------------------------------------------
   // protocol engine
   // ----------------------------------------------------------------
   smem_state_e state_r, state_nxt;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic ackPhase_r, ackPhase_nxt;
   logic ackOk_r, ackOk_nxt;
   logic byteFull_r, byteFull_nxt;
   logic [SMEM_ADDR_W-1:0] addr_r, addr_nxt;
   logic [SMEM_ADDR_W-1:0] hiAddr_r, hiAddr_nxt;
   logic sdaOut_r, sdaOut_nxt;
   logic sdaOe_r, sdaOe_nxt;
   logic busy_r, busy_nxt;
   logic [7:0] rxByte;

   function automatic logic [SMEM_ADDR_W-1:0] addrInc(
      input logic [SMEM_ADDR_W-1:0] a
   );
      // natural overflow gives the wrap from last location to zero
      addrInc = a + SMEM_ADDR_W'(1);
   endfunction

   assign rxByte = {shift_r[6:0], sdaIn};

   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      ackPhase_nxt = ackPhase_r;
      ackOk_nxt = ackOk_r;
      byteFull_nxt = byteFull_r;
      addr_nxt = addr_r;
      hiAddr_nxt = hiAddr_r;
      sdaOut_nxt = sdaOut_r;
      sdaOe_nxt = sdaOe_r;
      busy_nxt = (state_r != SMEM_IDLE);
      memReq.we = 1'b0;
      memReq.addr = addr_r;
      memReq.wdata = shift_r;
      if (startSeen) begin
         // a repeated start keeps the loaded address
         state_nxt = SMEM_DEVADDR;
         bitCnt_nxt = SMEM_BIT_FIRST;
         byteFull_nxt = 1'b0;
         ackPhase_nxt = 1'b0;
         sdaOe_nxt = 1'b0;
      end else if (stopSeen) begin
         state_nxt = SMEM_IDLE;
         byteFull_nxt = 1'b0;
         sdaOe_nxt = 1'b0;
      end else if (sclRise && state_r != SMEM_IDLE) begin
         if (ackPhase_r) begin
            if (state_r == SMEM_RACK) begin
               // master ack continues the sequential read
               ackOk_nxt = ~sdaIn;
            end
         end else begin
            shift_nxt = rxByte;
            if (state_r == SMEM_RDATA) begin
               shift_nxt = {shift_r[6:0], 1'b0};
            end
            if (state_r != SMEM_RDATA && bitCnt_r == SMEM_BIT_LAST) begin
               byteFull_nxt = 1'b1;
            end
            bitCnt_nxt = bitCnt_r + 3'h1;
         end
      end else if (sclFall && state_r != SMEM_IDLE) begin
         if (!ackPhase_r && byteFull_r && state_r != SMEM_RDATA) begin
            // a zero bit count alone also matches the first fall after
            // a start, so a flag marks the eighth bit instead
            byteFull_nxt = 1'b0;
            ackPhase_nxt = 1'b1;
            sdaOut_nxt = 1'b0;
            sdaOe_nxt = 1'b1;
            case (state_r)
               SMEM_DEVADDR: begin
                  if (shift_r[7:4] != SMEM_TYPE_CODE ||
                      shift_r[3:1] != selectPins) begin
                     state_nxt = SMEM_IDLE;
                     ackPhase_nxt = 1'b0;
                     sdaOe_nxt = 1'b0;
                  end
               end
               SMEM_WDATA: begin
                  if (writeProtect) begin
                     sdaOe_nxt = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end else if (ackPhase_r) begin
            // ack bit finished
            ackPhase_nxt = 1'b0;
            sdaOe_nxt = 1'b0;
            bitCnt_nxt = SMEM_BIT_FIRST;
            case (state_r)
               SMEM_DEVADDR: begin
                  if (shift_r[0] == SMEM_DIR_READ) begin
                     // current address read uses the counter
                     state_nxt = SMEM_RDATA;
                  end else begin
                     state_nxt = SMEM_ADDRHI;
                  end
               end
               SMEM_ADDRHI: begin
                  hiAddr_nxt = {shift_r[4:0], 8'h00};
                  state_nxt = SMEM_ADDRLO;
               end
               SMEM_ADDRLO: begin
                  // counter loaded only by an address phase
                  addr_nxt = hiAddr_r | {5'h00, shift_r};
                  state_nxt = SMEM_WDATA;
               end
               SMEM_WDATA: begin
                  // write commits when protect is low
                  memReq.we = ~writeProtect;
                  addr_nxt = addrInc(addr_r);
               end
               SMEM_RACK: begin
                  if (ackOk_r) begin
                     state_nxt = SMEM_RDATA;
                  end else begin
                     state_nxt = SMEM_IDLE;
                  end
               end
               default: begin
               end
            endcase
            if (state_nxt == SMEM_RDATA) begin
               shift_nxt = memRdata;
               sdaOut_nxt = memRdata[7];
               sdaOe_nxt = ~memRdata[7];
            end
         end else if (state_r == SMEM_RDATA) begin
            if (bitCnt_r == SMEM_BIT_FIRST) begin
               // eight bits out, release for master ack
               state_nxt = SMEM_RACK;
               ackPhase_nxt = 1'b1;
               sdaOe_nxt = 1'b0;
               addr_nxt = addrInc(addr_r);
            end else begin
               sdaOut_nxt = shift_r[7];
               sdaOe_nxt = ~shift_r[7];
            end
         end
      end
   end

   // read data is looked up one cycle ahead from the current counter
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r <= SMEM_IDLE;
         bitCnt_r <= SMEM_BIT_FIRST;
         shift_r <= 8'h00;
         ackPhase_r <= 1'b0;
         ackOk_r <= 1'b0;
         byteFull_r <= 1'b0;
         addr_r <= '0;
         hiAddr_r <= '0;
         sdaOut_r <= 1'b1;
         sdaOe_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         ackPhase_r <= ackPhase_nxt;
         ackOk_r <= ackOk_nxt;
         byteFull_r <= byteFull_nxt;
         addr_r <= addr_nxt;
         hiAddr_r <= hiAddr_nxt;
         sdaOut_r <= sdaOut_nxt;
         sdaOe_r <= sdaOe_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign sdaOut = sdaOut_r;
   assign sdaOe = sdaOe_r;
   assign busy = busy_r;
endmodule

// ==== testbench/smem_i2c_slave_asserts.sv ====
`timescale 1ns/10ps
module smem_i2c_slave_chk (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic scl,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic writeProtect,
   input wire logic [smem_pkg::SMEM_SEL_W-1:0] selectPins,
   input wire logic busy
);
   import smem_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence startSeen;
      scl && $past(scl) && $fell(sdaIn);
   endsequence
   sequence stopSeen;
      scl && $past(scl) && $rose(sdaIn);
   endsequence
   reset_quiet_a: assert property ($fell(reset) |-> !sdaOe && !busy)
      else $error("line driven or busy after reset");
   rise_low_clk_a: assert property ($rose(sdaOe) |-> !scl)
      else $error("data driven while clock high");
   release_low_a: assert property ($fell(sdaOe) |-> !scl)
      else $error("data released while clock high");
   hold_high_a: assert property (sdaOe && scl |=> sdaOe || !scl)
      else $error("data changed during clock high");
   drive_low_a: assert property (sdaOe |-> !sdaOut)
      else $error("open drain driven high");
   start_busy_a: assert property (startSeen |-> ##[1:6] busy)
      else $error("start did not wake the engine");
   stop_idle_a: assert property (stopSeen |-> ##[1:6] !busy)
      else $error("stop did not return to standby");
   oe_in_busy_a: assert property (sdaOe |-> busy)
      else $error("line driven outside a transfer");
endmodule
bind smem_i2c_slave smem_i2c_slave_chk i_chk (.ref_clk, .reset, .scl,
   .sdaIn, .sdaOut, .sdaOe, .writeProtect, .selectPins, .busy);

// ==== testbench/smem_i2c_master.sv ====
`timescale 1ns/10ps
module smem_i2c_master (
   input wire logic ref_clk,
   input wire logic sda,
   output logic scl,
   output logic sdaRel
);
   initial begin
      scl = 1'b1;
      sdaRel = 1'b1;
   end
   // release only
   // sdaRel high lets the pull-up lift the line; never driven high
   task automatic step(input logic c, input logic d);
      scl <= c;
      sdaRel <= d;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic start();
      step(1'b0, sdaRel);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, sdaRel);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic bitx(input logic b, output logic r);
      step(1'b0, sdaRel);
      step(1'b0, b);
      step(1'b1, b);
      r = sda;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ackIn,
                       output logic [7:0] rx, output logic ackOut);
      for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
      bitx(ackIn, ackOut);
   endtask
endmodule

// ==== testbench/test_smem_i2c_slave.sv ====
`timescale 1ns/10ps
module test_smem_i2c_slave;
   import smem_pkg::*;
   logic ref_clk, reset, writeProtect, sdaOut, sdaOe, busy, scl, sdaRel;
   logic [SMEM_SEL_W-1:0] selectPins;
   logic [7:0] rx;
   logic a;
   int nErrors, numChecks;
   wire logic sda;
   assign sda = sdaRel & ~sdaOe;
   smem_i2c_slave i_dut (.ref_clk, .reset, .scl, .sdaIn(sda), .sdaOut,
      .sdaOe, .writeProtect, .selectPins, .busy);
   smem_i2c_master i_mst (.ref_clk, .sda, .scl, .sdaRel);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // -------------------------
   // helpers
   // -------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic word(input logic rw, input logic [2:0] sel);
      i_mst.xfer({SMEM_TYPE_CODE, sel, rw}, 1'b1, rx, a);
   endtask
   task automatic setAddr(input logic [7:0] hi, input logic [7:0] lo);
      i_mst.start();
      word(1'b0, selectPins);
      chk({7'h0, a}, 8'h0);
      i_mst.xfer(hi, 1'b1, rx, a);
      chk({7'h0, a}, 8'h0);
      i_mst.xfer(lo, 1'b1, rx, a);
      chk({7'h0, a}, 8'h0);
   endtask
   task automatic rdCur(input int n, input logic [31:0] e);
      i_mst.start();
      word(1'b1, selectPins);
      chk({7'h0, a}, 8'h0);
      for (int i = 0; i < n; i++) begin
         i_mst.xfer(8'hff, i == n - 1, rx, a);
         chk(rx, e[31-8*i -: 8]);
      end
      i_mst.stop();
   endtask
   // -------------------------
   // scenarios
   // -------------------------
   task automatic t_write_wrap();
      writeProtect <= 1'b0;
      setAddr(8'hff, 8'hff);
      for (int i = 0; i < 4; i++) begin
         i_mst.xfer(8'(8'ha0 + i), 1'b1, rx, a);
         chk({7'h0, a}, 8'h0);
      end
      i_mst.stop();
      setAddr(8'h1f, 8'hff);
      rdCur(3, 32'ha0a1a200);
      rdCur(1, 32'ha3000000);
   endtask
   task automatic t_protect();
      writeProtect <= 1'b1;
      setAddr(8'h00, 8'h00);
      i_mst.xfer(8'h55, 1'b1, rx, a);
      chk({7'h0, a}, 8'h1);
      i_mst.stop();
      setAddr(8'h00, 8'h00);
      rdCur(1, 32'ha1000000);
      writeProtect <= 1'b0;
   endtask
   task automatic t_curr_wrap();
      setAddr(8'h1f, 8'hff);
      rdCur(1, 32'ha0000000);
      rdCur(1, 32'ha1000000);
   endtask
   task automatic t_bad_sel();
      i_mst.start();
      word(1'b0, selectPins ^ 3'h1);
      chk({7'h0, a}, 8'h1);
      i_mst.start();
      i_mst.xfer({~SMEM_TYPE_CODE, selectPins, 1'b0}, 1'b1, rx, a);
      chk({7'h0, a}, 8'h1);
      i_mst.stop();
      rdCur(1, 32'ha2000000);
   endtask
   task automatic t_abort();
      setAddr(8'h00, 8'h00);
      for (int i = 0; i < 4; i++) i_mst.bitx(1'b0, a);
      i_mst.stop();
      chk({7'h0, busy}, 8'h0);
      setAddr(8'h00, 8'h01);
      rdCur(1, 32'ha2000000);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // a full run needs about 5000 cycles
   initial begin
      repeat (30000) @(posedge ref_clk);
      nErrors++;
      stop_test();
   end
   initial begin
      reset = 1'b1;
      writeProtect = 1'b0;
      selectPins = 3'h5;
      nErrors = 0;
      numChecks = 0;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_write_wrap();
      t_protect();
      t_curr_wrap();
      t_bad_sel();
      t_abort();
      stop_test();
   end
endmodule
